// ==== stamp_pkg.sv ====
package stamp_pkg;
    localparam int unsigned count_width = 64;
    localparam int unsigned half_width = 32;
    localparam int unsigned aux_width = 32;
    localparam logic [31:0] stamp_count_addr = 32'h0000_0010;
    localparam logic [31:0] aux_signature_addr = 32'hC000_0103;
    localparam logic [63:0] count_reset = 64'h0000_0000_0000_0000;
    localparam logic [31:0] aux_reset = 32'h0000_0000;
    localparam int unsigned present_bit = 4;
    localparam int unsigned tsd_bit = 2;
    localparam int unsigned invariant_bit = 8;
    localparam int unsigned paired_bit = 27;
    localparam logic [31:0] leaf_basic = 32'h0000_0001;
    localparam logic [31:0] leaf_ext_one = 32'h8000_0001;
    localparam logic [31:0] leaf_ext_seven = 32'h8000_0007;
    localparam int unsigned clock_mhz = 250;
    localparam int unsigned wrap_years = 10;
    typedef enum logic [1:0] {
        rate_core,
        rate_const,
        rate_invariant
    } rate_mode_t;
    typedef enum logic [1:0] {
        op_none,
        op_read,
        op_read_paired,
        op_model_read
    } read_op_t;
endpackage : stamp_pkg

// ==== stamp_tick_gen.sv ====
`timescale 1ns/100ps
// Produces the counting events for each rate mode.
module stamp_tick_gen #(
    parameter int unsigned DIV_WIDTH = 8
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire stamp_pkg::rate_mode_t rate_mode,
    input wire logic core_clk_en,
    input wire logic [DIV_WIDTH-1:0] const_divide,
    input wire logic deep_sleep_pin,
    output logic tick
);
    logic [DIV_WIDTH-1:0] div_reg;
    logic [DIV_WIDTH-1:0] div_next;
    logic div_wrap;
    logic tick_next;

    initial begin
        if (DIV_WIDTH < 1 || DIV_WIDTH > 16) begin
            $error("DIV_WIDTH out of range");
        end
    end

    // Constant rate ignores the core clock gate, so frequency steps stay out
    assign div_wrap = (div_reg >= const_divide);
    assign div_next = div_wrap ? '0 : div_reg + 1'b1;
    assign tick_next = deep_sleep_pin ? 1'b0 : // [R3]
        (rate_mode == stamp_pkg::rate_core) ? core_clk_en : // [R4]
        div_wrap; // [R5] [R14]

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            div_reg <= '0;
            tick <= 1'b0;
        end else begin
            div_reg <= deep_sleep_pin ? div_reg : div_next;
            tick <= tick_next;
        end
    end

    a_sleep_no_tick: assert property (@(posedge clock) disable iff (sys_rst)
        deep_sleep_pin |=> !tick) // [R3]
        else $error("tick during deep sleep");
    a_const_period: assert property (@(posedge clock) disable iff (sys_rst)
        (rate_mode != stamp_pkg::rate_core && !deep_sleep_pin
         && const_divide == '0 && $past(!deep_sleep_pin)) |=> tick) // [R5]
        else $error("constant rate tick missing");
endmodule : stamp_tick_gen

// ==== cycle_stamp_counter.sv ====
`timescale 1ns/100ps
// How it works
// R1: 64-bit counter cleared to zero on reset
// R2: keeps counting through halt and stop-clock
// R3: deep-sleep pin freezes the counter
// R4: legacy mode counts every core clock
// R5: constant mode counts at fixed divided rate
// R6: reads return strictly increasing values; code returns the same count again when no event falls between two reads
// R7: rate slow enough: no wrap in ten years
// R8: read gated to ring 0 when disable set
// R9: read samples without waiting for others
// R10: model register 10H reads, writes counter
// R11: older write loads low half, clears high
// R12: newer write loads all 64 bits
// R13: query leaf 1 EDX bit 4 reports counter
// R14: invariant support in leaf 80000007H bit 8
// R15: 32-bit auxiliary signature register, software set
// R16: paired read returns count and signature together
// R17: paired read flag at 80000001H bit 27
// R18: each event adds one, wraps to zero
module cycle_stamp_counter #(
    parameter stamp_pkg::rate_mode_t RATE_MODE = stamp_pkg::rate_invariant,
    parameter bit FULL_WRITE = 1'b1,
    parameter int unsigned DIV_WIDTH = 8
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic core_clk_en,
    input wire logic [DIV_WIDTH-1:0] const_divide,
    input wire logic halted,
    input wire logic stop_clock_pin,
    input wire logic deep_sleep_pin,
    input wire logic [31:0] control_register_four,
    input wire logic [1:0] cur_priv,
    input wire logic v86_mode,
    input wire logic read_stamp_instruction,
    input wire logic paired_stamp_read_instruction,
    input wire logic model_register_read,
    input wire logic model_register_write,
    input wire logic [31:0] model_addr,
    input wire logic [63:0] model_wdata,
    input wire logic feature_query_instruction,
    input wire logic [31:0] query_leaf,
    output logic read_valid,
    output logic read_fault,
    output logic [31:0] eax_out,
    output logic [31:0] edx_out,
    output logic [31:0] ecx_out,
    output logic ecx_valid,
    output logic model_fault
);
    localparam int unsigned cw = stamp_pkg::count_width;
    localparam int unsigned hw = stamp_pkg::half_width;

    logic [63:0] cycle_stamp_count_reg;
    logic [63:0] count_next;
    logic [31:0] stamp_aux_signature_reg;
    logic [31:0] aux_next;
    logic tick;
    logic stamp_disable_flag;
    logic ring0;
    logic instr_ok;
    logic any_instr;
    logic hit_count;
    logic hit_aux;
    logic wr_count;
    logic wr_aux;
    logic [63:0] write_value;
    logic [63:0] read_value;
    logic [31:0] query_edx;
    logic model_ok;
    logic read_valid_next;
    logic read_fault_next;
    logic ecx_valid_next;
    logic model_fault_next;
    logic [31:0] eax_next;
    logic [31:0] edx_next;
    logic [31:0] ecx_next;

    initial begin
        if (DIV_WIDTH < 1 || DIV_WIDTH > 16) begin
            $error("DIV_WIDTH out of range");
        end
    end

    // Adds one with natural 64-bit wrap
    function automatic logic [63:0] bump(input logic [63:0] v);
        bump = v + 64'h0000_0000_0000_0001; // [R18]
    endfunction : bump

    // Low word of a 64-bit value
    function automatic logic [31:0] low_half(input logic [63:0] v);
        low_half = v[hw-1:0];
    endfunction : low_half

    stamp_tick_gen #(
        .DIV_WIDTH(DIV_WIDTH)
    ) u_tick (
        .clock(clock),
        .sys_rst(sys_rst),
        .rate_mode(RATE_MODE),
        .core_clk_en(core_clk_en),
        .const_divide(const_divide),
        .deep_sleep_pin(deep_sleep_pin),
        .tick(tick)
    );

    // Halt and stop-clock deliberately not used to gate counting
    // 64 bits at 250 MHz wrap after centuries, so ten years is safe [R7]
    assign stamp_disable_flag = control_register_four[stamp_pkg::tsd_bit];
    assign ring0 = (cur_priv == 2'h0) && !v86_mode;
    assign instr_ok = !stamp_disable_flag || ring0; // [R8]
    assign any_instr = read_stamp_instruction
        || paired_stamp_read_instruction;

    assign hit_count = (model_addr == stamp_pkg::stamp_count_addr); // [R10]
    assign hit_aux = (model_addr == stamp_pkg::aux_signature_addr);
    assign model_ok = ring0 && (hit_count || hit_aux);
    assign wr_count = model_register_write && model_ok && hit_count;
    assign wr_aux = model_register_write && model_ok && hit_aux; // [R15]

    assign write_value = FULL_WRITE ? model_wdata // [R12]
        : {32'h0000_0000, low_half(model_wdata)}; // [R11]

    // Software write wins over a tick in the same cycle
    assign count_next = wr_count ? write_value
        : tick ? bump(cycle_stamp_count_reg) // [R2] [R4] [R5] [R18]
        : cycle_stamp_count_reg;
    assign aux_next = wr_aux ? low_half(model_wdata)
        : stamp_aux_signature_reg;

    // Reads see the live count with no ordering stall
    assign read_value = hit_aux ? {32'h0000_0000, stamp_aux_signature_reg}
        : cycle_stamp_count_reg; // [R9] [R10]

    assign query_edx =
        (query_leaf == stamp_pkg::leaf_basic)
            ? (32'h0000_0001 << stamp_pkg::present_bit) // [R13]
        : (query_leaf == stamp_pkg::leaf_ext_one)
            ? (32'h0000_0001 << stamp_pkg::paired_bit) // [R17]
        : (query_leaf == stamp_pkg::leaf_ext_seven
           && RATE_MODE == stamp_pkg::rate_invariant)
            ? (32'h0000_0001 << stamp_pkg::invariant_bit) // [R14]
        : 32'h0000_0000;

    assign read_valid_next = (any_instr && instr_ok)
        || (model_register_read && model_ok)
        || feature_query_instruction;
    assign read_fault_next = any_instr && !instr_ok; // [R8]
    assign model_fault_next = (model_register_read || model_register_write)
        && !model_ok;
    assign ecx_valid_next = paired_stamp_read_instruction && instr_ok;

    assign eax_next = feature_query_instruction ? 32'h0000_0000
        : (any_instr && instr_ok) ? low_half(cycle_stamp_count_reg)
        : (model_register_read && model_ok) ? low_half(read_value)
        : 32'h0000_0000;
    assign edx_next = feature_query_instruction ? query_edx
        : (any_instr && instr_ok) ? cycle_stamp_count_reg[cw-1:hw]
        : (model_register_read && model_ok) ? read_value[cw-1:hw]
        : 32'h0000_0000;
    // Same-cycle sample of count and signature keeps them indivisible
    assign ecx_next = ecx_valid_next ? stamp_aux_signature_reg // [R16]
        : 32'h0000_0000;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cycle_stamp_count_reg <= stamp_pkg::count_reset; // [R1]
            stamp_aux_signature_reg <= stamp_pkg::aux_reset;
        end else begin
            cycle_stamp_count_reg <= count_next;
            stamp_aux_signature_reg <= aux_next;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            read_valid <= 1'b0;
            read_fault <= 1'b0;
            model_fault <= 1'b0;
            ecx_valid <= 1'b0;
            eax_out <= 32'h0000_0000;
            edx_out <= 32'h0000_0000;
            ecx_out <= 32'h0000_0000;
        end else begin
            read_valid <= read_valid_next;
            read_fault <= read_fault_next;
            model_fault <= model_fault_next;
            ecx_valid <= ecx_valid_next;
            eax_out <= eax_next;
            edx_out <= edx_next;
            ecx_out <= ecx_next;
        end
    end

    a_reset_zero: assert property (@(posedge clock)
        $fell(sys_rst) |-> cycle_stamp_count_reg == 64'h0) // [R1]
        else $error("count not zero after reset");
    a_tick_adds_one: assert property (@(posedge clock) disable iff (sys_rst)
        (tick && !wr_count) |=>
        cycle_stamp_count_reg == $past(cycle_stamp_count_reg) + 64'h1)
        // [R18]
        else $error("tick did not add one");
    a_halt_counts: assert property (@(posedge clock) disable iff (sys_rst)
        (tick && (halted || stop_clock_pin) && !wr_count) |=>
        cycle_stamp_count_reg != $past(cycle_stamp_count_reg)) // [R2]
        else $error("halt stopped count");
    a_sleep_holds: assert property (@(posedge clock) disable iff (sys_rst)
        (deep_sleep_pin && !wr_count) ##1 (deep_sleep_pin && !wr_count)
        |=> $stable(cycle_stamp_count_reg)) // [R3]
        else $error("count moved in deep sleep");
    a_no_tick_holds: assert property (@(posedge clock) disable iff (sys_rst)
        (!tick && !wr_count) |=> $stable(cycle_stamp_count_reg)) // [R6]
        else $error("count moved without event");
    a_priv_fault: assert property (@(posedge clock) disable iff (sys_rst)
        (read_stamp_instruction && stamp_disable_flag && cur_priv != 2'h0)
        |=> read_fault && !read_valid) // [R8]
        else $error("user read not refused");
    a_paired_sig: assert property (@(posedge clock) disable iff (sys_rst)
        (paired_stamp_read_instruction && instr_ok) |=>
        ecx_valid && ecx_out == $past(stamp_aux_signature_reg)
        && eax_out == $past(cycle_stamp_count_reg[31:0])) // [R16]
        else $error("paired read mismatch");
    a_write_half: assert property (@(posedge clock) disable iff (sys_rst)
        (wr_count && !FULL_WRITE) |=>
        cycle_stamp_count_reg[63:32] == 32'h0) // [R11]
        else $error("high half not cleared");
    a_write_full: assert property (@(posedge clock) disable iff (sys_rst)
        (wr_count && FULL_WRITE) |=>
        cycle_stamp_count_reg == $past(model_wdata)) // [R12]
        else $error("full write lost");
    a_query_bit: assert property (@(posedge clock) disable iff (sys_rst)
        (feature_query_instruction && query_leaf == 32'h1) |=>
        edx_out[4]) // [R13]
        else $error("present flag missing");

    // Refusal must reach software; a silent drop would hide the access
    a_model_refuse: assert property (@(posedge clock) disable iff (sys_rst)
        ((model_register_read || model_register_write) && !ring0)
        |=> model_fault) // [R10]
        else $error("non ring 0 model access not refused");

    a_model_count: assert property (@(posedge clock) disable iff (sys_rst)
        (model_register_read && ring0 && hit_count
         && !feature_query_instruction && !any_instr)
        |=> read_valid
        && {edx_out, eax_out} == $past(cycle_stamp_count_reg)) // [R10]
        else $error("model read of count wrong");

    a_aux_write: assert property (@(posedge clock) disable iff (sys_rst)
        wr_aux |=>
        stamp_aux_signature_reg == $past(model_wdata[31:0])) // [R15]
        else $error("signature write lost");

    a_aux_read: assert property (@(posedge clock) disable iff (sys_rst)
        (model_register_read && ring0 && hit_aux
         && !feature_query_instruction && !any_instr)
        |=> edx_out == 32'h0000_0000
        && eax_out == $past(stamp_aux_signature_reg)) // [R15]
        else $error("model read of signature wrong");

    // Value sampled at the request edge, before that edge's update
    a_read_value: assert property (@(posedge clock) disable iff (sys_rst)
        (read_stamp_instruction && instr_ok && !feature_query_instruction)
        |=> read_valid
        && {edx_out, eax_out} == $past(cycle_stamp_count_reg)) // [R6] [R9]
        else $error("stamp read value wrong");

    a_paired_high: assert property (@(posedge clock) disable iff (sys_rst)
        (paired_stamp_read_instruction && instr_ok
         && !feature_query_instruction)
        |=> edx_out == $past(cycle_stamp_count_reg[63:32])) // [R16]
        else $error("paired read high word wrong");

    a_ext_flag: assert property (@(posedge clock) disable iff (sys_rst)
        (feature_query_instruction
         && query_leaf == stamp_pkg::leaf_ext_one)
        |=> edx_out[27]) // [R17]
        else $error("paired read flag missing");

    a_invariant_flag: assert property (@(posedge clock) disable iff (sys_rst)
        (feature_query_instruction
         && query_leaf == stamp_pkg::leaf_ext_seven)
        |=> edx_out[8] == (RATE_MODE == stamp_pkg::rate_invariant)) // [R14]
        else $error("invariant flag wrong");

    // Virtual-8086 code is never ring 0, whatever the level field says
    a_v86_refuse: assert property (@(posedge clock) disable iff (sys_rst)
        (read_stamp_instruction && stamp_disable_flag && v86_mode)
        |=> read_fault) // [R8]
        else $error("v86 read not refused");

    a_open_read: assert property (@(posedge clock) disable iff (sys_rst)
        (any_instr && !stamp_disable_flag) |=> !read_fault) // [R8]
        else $error("read refused while allowed");

    a_ecx_idle: assert property (@(posedge clock) disable iff (sys_rst)
        !ecx_valid |-> ecx_out == 32'h0000_0000) // [R16]
        else $error("signature shown without paired read");

    a_write_wins: assert property (@(posedge clock) disable iff (sys_rst)
        (wr_count && tick)
        |=> cycle_stamp_count_reg == $past(write_value)) // [R11] [R12]
        else $error("tick beat a software write");

    a_wrap_zero: assert property (@(posedge clock) disable iff (sys_rst)
        (tick && !wr_count && (&cycle_stamp_count_reg))
        |=> cycle_stamp_count_reg == 64'h0000_0000_0000_0000) // [R18]
        else $error("count did not wrap to zero");

    c_user_read: cover property (@(posedge clock) disable iff (sys_rst)
        read_stamp_instruction && instr_ok && cur_priv == 2'h3);
    c_paired: cover property (@(posedge clock) disable iff (sys_rst)
        paired_stamp_read_instruction && instr_ok);
    c_sleep: cover property (@(posedge clock) disable iff (sys_rst)
        deep_sleep_pin ##1 !deep_sleep_pin);
    c_write: cover property (@(posedge clock) disable iff (sys_rst)
        wr_count);
    c_wrap: cover property (@(posedge clock) disable iff (sys_rst)
        tick && (&cycle_stamp_count_reg));
endmodule : cycle_stamp_counter

// ==== cycle_stamp_counter_tb.sv ====
`timescale 1ns/100ps
module cycle_stamp_counter_tb;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic core_clk_en = 1'b0;
    logic [7:0] const_divide = 8'h03;
    logic halted = 1'b0;
    logic stop_clock_pin = 1'b0;
    logic deep_sleep_pin = 1'b0;
    logic [31:0] control_register_four = 32'h0;
    logic [1:0] cur_priv = 2'h0;
    logic v86_mode = 1'b0;
    logic read_stamp_instruction = 1'b0;
    logic paired_stamp_read_instruction = 1'b0;
    logic model_register_read = 1'b0;
    logic model_register_write = 1'b0;
    logic [31:0] model_addr = 32'h0;
    logic [63:0] model_wdata = 64'h0;
    logic feature_query_instruction = 1'b0;
    logic [31:0] query_leaf = 32'h0;
    logic read_valid, read_fault, ecx_valid, model_fault;
    logic [31:0] eax_out, edx_out, ecx_out, old_eax, old_edx;
    logic [3:0] resp;
    logic [63:0] got, got_old, prev;
    logic [31:0] got_ecx;
    logic [31:0] seed = 32'hC214;
    longint unsigned model_count = 0;
    longint unsigned old_count = 0;
    logic [31:0] model_aux = 32'h0;
    int err_total = 0;
    int comparisons = 0;

    cycle_stamp_counter #(.RATE_MODE(stamp_pkg::rate_core),
        .FULL_WRITE(1'b1), .DIV_WIDTH(8)) i_dut (.*);
    // Older write variant runs alongside on the same stimulus
    cycle_stamp_counter #(.RATE_MODE(stamp_pkg::rate_core),
        .FULL_WRITE(1'b0), .DIV_WIDTH(8)) i_old (.*, .read_valid(),
        .read_fault(), .eax_out(old_eax), .edx_out(old_edx), .ecx_out(),
        .ecx_valid(), .model_fault());

    initial begin
        forever #2 clock = ~clock;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    task automatic check(input logic [63:0] g, input logic [63:0] e,
        input string what);
        comparisons++;
        if (g !== e) begin
            $display("mismatch at %0t: %s got %h want %h", $time, what, g, e);
            err_total++;
        end
    endtask : check

    task automatic issue(input int kind, input logic [31:0] addr,
        input logic [63:0] wd);
        @(negedge clock);
        model_addr = addr;
        query_leaf = addr;
        model_wdata = wd;
        read_stamp_instruction = (kind == 0);
        paired_stamp_read_instruction = (kind == 1);
        model_register_read = (kind == 2);
        model_register_write = (kind == 3);
        feature_query_instruction = (kind == 4);
        resp = 4'h0;
        // Bounded wait; writes answer nothing unless refused
        for (int i = 0; i < 4 && resp == 4'h0; i++) begin
            @(negedge clock);
            {read_stamp_instruction, paired_stamp_read_instruction} = 2'h0;
            {model_register_read, model_register_write} = 2'h0;
            feature_query_instruction = 1'b0;
            resp = {read_valid, read_fault, model_fault, ecx_valid};
            got = {edx_out, eax_out};
            got_old = {old_edx, old_eax};
            got_ecx = ecx_out;
        end
    endtask : issue

    task automatic stamp_read;
        issue(0, 32'h0, 64'h0);
        check({60'h0, resp}, 64'h8, "read response");
        check(got, model_count, "count");
        check(got_old, old_count, "older count");
    endtask : stamp_read

    // Enable dropped and pipeline flushed so reads see a frozen count
    task automatic run(input int n, input bit rnd);
        for (int i = 0; i < n; i++) begin
            @(negedge clock);
            seed = xorshift(seed);
            core_clk_en = rnd ? seed[0] : 1'b1;
            if (core_clk_en && !deep_sleep_pin) begin
                model_count++;
                old_count++;
            end
        end
        @(negedge clock);
        core_clk_en = 1'b0;
        repeat (4) @(negedge clock);
    endtask : run

    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    initial begin
        repeat (2) @(negedge clock);
        sys_rst = 1'b0;
        stamp_read();
        seed = xorshift(seed);
        model_aux = seed;
        issue(3, stamp_pkg::aux_signature_addr, {32'h0, seed});
        issue(2, stamp_pkg::aux_signature_addr, 64'h0);
        check(got, {32'h0, model_aux}, "aux read");
        $display("test reset and aux done");
        prev = 64'hFFFF_FFFF_FFFF_FFFE;
        issue(3, stamp_pkg::stamp_count_addr, prev);
        model_count = prev;
        old_count = {32'h0, prev[31:0]};
        stamp_read();
        run(3, 1'b0);
        stamp_read();
        $display("test write and wrap done");
        {halted, stop_clock_pin} = 2'h3;
        run(20, 1'b0);
        issue(2, stamp_pkg::stamp_count_addr, 64'h0);
        check(got, model_count, "model read");
        {halted, stop_clock_pin, deep_sleep_pin} = 3'h1;
        run(10, 1'b0);
        deep_sleep_pin = 1'b0;
        stamp_read();
        $display("test halt and sleep done");
        for (int n = 0; n < 8; n++) begin
            prev = model_count;
            run(4 + seed[3:0], 1'b1);
            stamp_read();
            check({63'h0, got > prev || got == model_count}, 64'h1, "rise");
        end
        $display("test random counting done");
        for (int c = 0; c < 16; c++) begin
            control_register_four = {seed[31:3], c[0], seed[1:0]};
            cur_priv = c[2:1];
            v86_mode = c[3];
            for (int k = 0; k < 2; k++) begin
                issue(k, 32'h0, 64'h0);
                if (!c[0] || c[3:1] == 3'h0) begin
                    check({60'h0, resp}, k ? 64'h9 : 64'h8, "grant");
                    check(got, model_count, "stamp");
                    if (k == 1) check({32'h0, got_ecx}, model_aux, "sig");
                end else begin
                    check({60'h0, resp}, 64'h4, "refusal");
                end
            end
        end
        $display("test privilege done");
        {control_register_four, v86_mode, cur_priv} = {32'h0, 3'h3};
        issue(3, stamp_pkg::stamp_count_addr, 64'h0);
        check({60'h0, resp}, 64'h2, "user write");
        cur_priv = 2'h0;
        issue(2, 32'h0000_0011, 64'h0);
        check({60'h0, resp}, 64'h2, "unmapped");
        stamp_read();
        issue(4, stamp_pkg::leaf_basic, 64'h0);
        check({63'h0, got[32 + stamp_pkg::present_bit]}, 64'h1, "present");
        issue(4, stamp_pkg::leaf_ext_one, 64'h0);
        check({63'h0, got[32 + stamp_pkg::paired_bit]}, 64'h1, "pair");
        issue(4, stamp_pkg::leaf_ext_seven, 64'h0);
        check({63'h0, got[32 + stamp_pkg::invariant_bit]}, 64'h0, "inv");
        $display("test model access and query done");
        sys_rst = 1'b1;
        @(negedge clock);
        sys_rst = 1'b0;
        model_count = 0;
        old_count = 0;
        stamp_read();
        issue(2, stamp_pkg::aux_signature_addr, 64'h0);
        check(got, 64'h0, "aux after reset");
        $display("test second reset done");
        results();
    end

    initial begin
        #20000;
        err_total++;
        $display("mismatch at %0t: watchdog expired", $time);
        results();
    end
endmodule : cycle_stamp_counter_tb
